// [hw/sbt_pkg.sv]
// Package for the shutter button telegram logic
package sbt_pkg;
	// Timing base: 100 MHz clock, times configured in 10 ms ticks
	localparam int CLK_FREQ_HZ = 100000000;
	localparam int TICK_TIME_MS = 10;
	localparam int TICK_CYCLES = CLK_FREQ_HZ / 1000 * TICK_TIME_MS;
	localparam int TICK_CNT_W = 20;
	localparam int TIME_W = 16;
	localparam logic [TICK_CNT_W-1:0] TICK_CNT_RST = 20'h00000;
	localparam logic [TIME_W-1:0] TIME_RST = 16'h0000;
	localparam logic [TIME_W-1:0] TIME_MAX = 16'hFFFF;
	localparam logic [7:0] POS_OPEN = 8'h00;
	localparam logic [7:0] POS_CLOSED = 8'hFF;
	localparam logic DIR_UP = 1'b0;
	localparam logic DIR_DOWN = 1'b1;
	localparam logic [3:0] DIM_BRIGHTER = 4'h9;
	localparam logic [3:0] DIM_DARKER = 4'h1;
	localparam logic [7:0] SCENE_SAVE_BIT = 8'h80;

	typedef enum logic [1:0] {
		SBT_DIR_UP = 2'b00,
		SBT_DIR_DOWN = 2'b01,
		SBT_DIR_TOGGLE = 2'b10
	} sbt_dir_mode_t;

	typedef enum logic [2:0] {
		SBT_UC_LONG_SHORT = 3'b000,
		SBT_UC_LONG_SHORT_TURN = 3'b001,
		SBT_UC_INVERTED = 3'b010,
		SBT_UC_SHORT_SHORT = 3'b011,
		SBT_UC_SHORT_LONG_TURN = 3'b100,
		SBT_UC_HOLD = 3'b101,
		SBT_UC_HOLD_TURN = 3'b110,
		SBT_UC_HOLD_DELAYED = 3'b111
	} sbt_ctrl_t;

	typedef enum logic [3:0] {
		SBT_AF_NONE = 4'h0,
		SBT_AF_ON = 4'h1,
		SBT_AF_OFF = 4'h2,
		SBT_AF_TOGGLE = 4'h3,
		SBT_AF_BRIGHTER = 4'h4,
		SBT_AF_DARKER = 4'h5,
		SBT_AF_DRIVE_UP = 4'h6,
		SBT_AF_DRIVE_DOWN = 4'h7,
		SBT_AF_STEP_UP = 4'h8,
		SBT_AF_STEP_DOWN = 4'h9,
		SBT_AF_VALUE = 4'hA,
		SBT_AF_SCENE_CALL = 4'hB,
		SBT_AF_SCENE_SAVE = 4'hC
	} sbt_addfn_t;

	typedef enum logic [1:0] {
		SBT_VT_PERCENT = 2'b00,
		SBT_VT_INT8 = 2'b01,
		SBT_VT_INT16 = 2'b10,
		SBT_VT_FLOAT16 = 2'b11
	} sbt_vtype_t;

	typedef enum logic [1:0] {
		SBT_ST_IDLE = 2'b00,
		SBT_ST_PRESSED = 2'b01,
		SBT_ST_DONE = 2'b10
	} sbt_state_t;

	// Static configuration
	typedef struct packed {
		logic value_mode;
		sbt_dir_mode_t dir_mode;
		sbt_ctrl_t ctrl;
		sbt_addfn_t addfn;
		logic very_long_en;
		logic tone_en;
		logic write_en;
		logic [TIME_W-1:0] long_time;
		logic [TIME_W-1:0] very_long_time;
		logic [TIME_W-1:0] turn_time;
		logic [TIME_W-1:0] drive_time;
		logic [7:0] add_value;
		logic [5:0] scene_num;
		sbt_vtype_t vtype;
		logic [15:0] send_value;
	} sbt_cfg_t;

	// Telegrams received from the bus
	typedef struct packed {
		logic drive_vld;
		logic drive_val;
		logic step_vld;
		logic step_val;
		logic pos_vld;
		logic [7:0] pos_val;
		logic sw_vld;
		logic sw_val;
	} sbt_rx_t;

	// Telegrams sent toward the bus, each strobe with its data
	typedef struct packed {
		logic drive_vld;
		logic drive_val;
		logic step_vld;
		logic step_val;
		logic sw_vld;
		logic sw_val;
		logic dim_vld;
		logic [3:0] dim_val;
		logic af_drive_vld;
		logic af_drive_val;
		logic af_step_vld;
		logic af_step_val;
		logic byte_vld;
		logic [7:0] byte_val;
		logic scene_vld;
		logic [7:0] scene_val;
		logic value_vld;
		sbt_vtype_t value_type;
		logic [15:0] value_val;
	} sbt_tx_t;
endpackage

// [hw/sbt_shutter_button.sv]
// Shutter button telegram logic for one binary input
//
// Contract
// - Send one-bit drive and step/stop telegrams
// - One common long-press time splits short/long
// - Direction fixed up, fixed down or toggling
// - Adopt received drive/step values when writable
// - Position limits set next toggle direction
// - Long/short: long drive, short step, very-long extra
// - Same plus step on release within turning
// - Inverted: short drive, long or driving step
// - Short/short: short drive, long extra function
// - Short and long drive, turning release step
// - Hold: press drives, release always steps
// - Hold turn: release within turning steps
// - Delayed hold: long drives, short extra
// - Inverted, short/short, short-long turn, delayed hold: drive-time window makes actuation a stop
// - Tone pulse when turning time expires
// - Extra switch on/off/toggle of tracked value
// - Extra dim, drive or step-stop telegram
// - Extra byte value, scene call or save
// - Separate threshold defines very long press
// - Send-value mode sends one typed value
`timescale 1ns/1ps
module sbt_shutter_button
	import sbt_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_button,
	input wire sbt_cfg_t i_cfg,
	input wire sbt_rx_t i_rx,
	output sbt_tx_t o_tx,
	output logic o_tone,
	output logic o_driving
);

	// ----------------------------------------------------------------
	// Time base
	// ----------------------------------------------------------------
	logic [TICK_CNT_W-1:0] tick_cnt_r;
	logic tick_r;

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			tick_cnt_r <= TICK_CNT_RST;
			tick_r <= 1'b0;
		end else if (tick_cnt_r == TICK_CNT_W'(TICK_CYCLES - 1)) begin
			tick_cnt_r <= TICK_CNT_RST;
			tick_r <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 1'b1;
			tick_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Press classification
	// ----------------------------------------------------------------
	sbt_state_t state_r;
	logic btn_q_r;
	logic [TIME_W-1:0] press_t_r;
	logic long_r;
	logic vlong_r;
	wire press_ev = i_button && !btn_q_r;
	wire release_ev = !i_button && btn_q_r;
	wire long_ev = (state_r == SBT_ST_PRESSED) && !long_r && (press_t_r >= i_cfg.long_time);
	wire vlong_ev = (state_r == SBT_ST_PRESSED) && long_r && !vlong_r && i_cfg.very_long_en &&
		(press_t_r >= i_cfg.very_long_time);

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			btn_q_r <= 1'b0;
		end else begin
			btn_q_r <= i_button;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			state_r <= SBT_ST_IDLE;
			press_t_r <= TIME_RST;
			long_r <= 1'b0;
			vlong_r <= 1'b0;
		end else begin
			case (state_r)
				SBT_ST_IDLE: begin
					if (press_ev) begin
						state_r <= SBT_ST_PRESSED;
						press_t_r <= TIME_RST;
						long_r <= 1'b0;
						vlong_r <= 1'b0;
					end
				end
				SBT_ST_PRESSED: begin
					if (release_ev) begin
						state_r <= SBT_ST_IDLE;
					end else begin
						if (tick_r && press_t_r != TIME_MAX) begin
							press_t_r <= press_t_r + 1'b1;
						end
						if (long_ev) begin
							long_r <= 1'b1;
						end
						if (vlong_ev) begin
							vlong_r <= 1'b1;
						end
					end
				end
				default: begin
					state_r <= SBT_ST_IDLE;
				end
			endcase
		end
	end

	wire short_rel = release_ev && (state_r == SBT_ST_PRESSED) && !long_r;
	wire long_rel = release_ev && (state_r == SBT_ST_PRESSED) && long_r;

	// ----------------------------------------------------------------
	// Turning and drive windows
	// ----------------------------------------------------------------
	logic [TIME_W-1:0] turn_t_r;
	logic turn_act_r;
	logic [TIME_W-1:0] drv_t_r;
	logic drv_act_r;
	logic turn_start;
	logic drive_send;

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			turn_t_r <= TIME_RST;
			turn_act_r <= 1'b0;
			o_tone <= 1'b0;
		end else begin
			o_tone <= 1'b0;
			if (turn_start) begin
				turn_t_r <= TIME_RST;
				turn_act_r <= 1'b1;
			end else if (turn_act_r && release_ev) begin
				turn_act_r <= 1'b0;
			end else if (turn_act_r && (turn_t_r >= i_cfg.turn_time)) begin
				// Closes after the configured ticks; zero means one cycle
				turn_act_r <= 1'b0;
				o_tone <= i_cfg.tone_en;
			end else if (turn_act_r && tick_r) begin
				// Elapsed ticks, never past the limit
				turn_t_r <= turn_t_r + 1'b1;
			end
		end
	end

	wire turn_in = turn_act_r;
	logic stop_send;

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			drv_t_r <= TIME_RST;
			drv_act_r <= 1'b0;
		end else begin
			if (drive_send) begin
				drv_t_r <= TIME_RST;
				drv_act_r <= 1'b1;
			end else if (stop_send || (i_cfg.write_en && i_rx.step_vld)) begin
				drv_act_r <= 1'b0;
			end else if (drv_act_r && tick_r) begin
				if (drv_t_r + 1'b1 >= i_cfg.drive_time) begin
					drv_act_r <= 1'b0;
				end else begin
					drv_t_r <= drv_t_r + 1'b1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Scheme decode
	// ----------------------------------------------------------------
	logic addfn_send;
	logic suppress_r;

	always_comb begin
		drive_send = 1'b0;
		stop_send = 1'b0;
		addfn_send = 1'b0;
		turn_start = 1'b0;
		if (!i_cfg.value_mode) begin
			case (i_cfg.ctrl)
				SBT_UC_LONG_SHORT, SBT_UC_LONG_SHORT_TURN: begin
					drive_send = long_ev;
					turn_start = long_ev && (i_cfg.ctrl == SBT_UC_LONG_SHORT_TURN);
					stop_send = short_rel || (long_rel && turn_in && !vlong_r);
					addfn_send = vlong_ev;
				end
				SBT_UC_INVERTED: begin
					stop_send = (press_ev && drv_act_r) || (long_ev && !suppress_r);
					drive_send = short_rel && !suppress_r;
					addfn_send = vlong_ev;
				end
				SBT_UC_SHORT_SHORT: begin
					stop_send = press_ev && drv_act_r;
					drive_send = short_rel && !suppress_r;
					addfn_send = long_ev && !suppress_r;
				end
				SBT_UC_SHORT_LONG_TURN: begin
					stop_send = (press_ev && drv_act_r) || (long_rel && turn_in && !vlong_r &&
						!suppress_r);
					drive_send = (short_rel || long_ev) && !suppress_r;
					turn_start = long_ev && !suppress_r;
					addfn_send = vlong_ev && !suppress_r;
				end
				SBT_UC_HOLD: begin
					drive_send = press_ev;
					stop_send = release_ev;
				end
				SBT_UC_HOLD_TURN: begin
					drive_send = press_ev;
					turn_start = press_ev;
					stop_send = release_ev && turn_in;
				end
				SBT_UC_HOLD_DELAYED: begin
					stop_send = (press_ev && drv_act_r) || (long_rel && turn_in && !suppress_r);
					drive_send = long_ev && !suppress_r;
					turn_start = long_ev && !suppress_r;
					addfn_send = short_rel && !suppress_r;
				end
				default: begin
					drive_send = 1'b0;
				end
			endcase
		end
	end

	// A press that stopped a drive does nothing else, except the very-long extra in inverted mode
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			suppress_r <= 1'b0;
		end else if (press_ev) begin
			suppress_r <= drv_act_r && (i_cfg.ctrl != SBT_UC_HOLD) &&
				(i_cfg.ctrl != SBT_UC_HOLD_TURN) && (i_cfg.ctrl != SBT_UC_LONG_SHORT) &&
				(i_cfg.ctrl != SBT_UC_LONG_SHORT_TURN);
		end
	end

	// ----------------------------------------------------------------
	// Direction and switch tracking
	// ----------------------------------------------------------------
	logic dir_r;
	logic sw_r;
	logic dir_now;

	always_comb begin
		case (i_cfg.dir_mode)
			SBT_DIR_UP: dir_now = DIR_UP;
			SBT_DIR_DOWN: dir_now = DIR_DOWN;
			default: dir_now = dir_r;
		endcase
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			dir_r <= DIR_UP;
		end else if (drive_send && i_cfg.dir_mode == SBT_DIR_TOGGLE) begin
			dir_r <= !dir_r;
		end else if (i_cfg.write_en && i_rx.drive_vld) begin
			dir_r <= !i_rx.drive_val;
		end else if (i_cfg.write_en && i_rx.step_vld) begin
			dir_r <= !i_rx.step_val;
		end else if (i_rx.pos_vld && i_rx.pos_val == POS_OPEN) begin
			dir_r <= DIR_DOWN;
		end else if (i_rx.pos_vld && i_rx.pos_val == POS_CLOSED) begin
			dir_r <= DIR_UP;
		end
	end

	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sw_r <= 1'b0;
		end else if (addfn_send && i_cfg.addfn == SBT_AF_TOGGLE) begin
			sw_r <= !sw_r;
		end else if (i_cfg.write_en && i_rx.sw_vld) begin
			sw_r <= i_rx.sw_val;
		end
	end

	// ----------------------------------------------------------------
	// Telegram outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_tx <= '0;
			o_driving <= 1'b0;
		end else begin
			o_tx <= '0;
			o_driving <= drv_act_r;
			o_tx.drive_vld <= drive_send;
			o_tx.drive_val <= dir_now;
			o_tx.step_vld <= stop_send;
			o_tx.step_val <= dir_now;
			if (i_cfg.value_mode && press_ev) begin
				o_tx.value_vld <= 1'b1;
				o_tx.value_type <= i_cfg.vtype;
				o_tx.value_val <= (i_cfg.vtype == SBT_VT_PERCENT || i_cfg.vtype == SBT_VT_INT8) ?
					{8'h00, i_cfg.send_value[7:0]} : i_cfg.send_value;
			end
			if (addfn_send) begin
				case (i_cfg.addfn)
					SBT_AF_ON, SBT_AF_OFF, SBT_AF_TOGGLE: begin
						o_tx.sw_vld <= 1'b1;
						o_tx.sw_val <= (i_cfg.addfn == SBT_AF_ON) ||
							(i_cfg.addfn == SBT_AF_TOGGLE && !sw_r);
					end
					SBT_AF_BRIGHTER, SBT_AF_DARKER: begin
						o_tx.dim_vld <= 1'b1;
						o_tx.dim_val <= (i_cfg.addfn == SBT_AF_BRIGHTER) ? DIM_BRIGHTER : DIM_DARKER;
					end
					SBT_AF_DRIVE_UP, SBT_AF_DRIVE_DOWN: begin
						o_tx.af_drive_vld <= 1'b1;
						o_tx.af_drive_val <= (i_cfg.addfn == SBT_AF_DRIVE_DOWN);
					end
					SBT_AF_STEP_UP, SBT_AF_STEP_DOWN: begin
						o_tx.af_step_vld <= 1'b1;
						o_tx.af_step_val <= (i_cfg.addfn == SBT_AF_STEP_DOWN);
					end
					SBT_AF_VALUE: begin
						o_tx.byte_vld <= 1'b1;
						o_tx.byte_val <= i_cfg.add_value;
					end
					SBT_AF_SCENE_CALL, SBT_AF_SCENE_SAVE: begin
						o_tx.scene_vld <= 1'b1;
						o_tx.scene_val <= {2'b00, i_cfg.scene_num} |
							((i_cfg.addfn == SBT_AF_SCENE_SAVE) ? SCENE_SAVE_BIT : 8'h00);
					end
					default: begin
						o_tx.sw_vld <= 1'b0;
					end
				endcase
			end
		end
	end

endmodule

// [verif/sbt_monitor.sv]
// Checker for the shutter button telegram logic
`timescale 1ns/1ps
module sbt_monitor
	import sbt_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_button,
	input wire sbt_cfg_t i_cfg,
	input wire sbt_rx_t i_rx,
	input wire sbt_tx_t o_tx,
	input wire logic o_tone,
	input wire logic o_driving
);
	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (!i_reset_n);
	wire logic hold_m = !i_cfg.value_mode && i_cfg.ctrl == SBT_UC_HOLD;
	// ------------------------------
	// Assertions
	// ------------------------------
	drive_pulse_a: assert property (o_tx.drive_vld |=> !o_tx.drive_vld)
		else $error("drive strobe longer than one cycle");
	step_pulse_a: assert property (o_tx.step_vld |=> !o_tx.step_vld)
		else $error("step strobe longer than one cycle");
	tone_gate_a: assert property (o_tone |-> i_cfg.tone_en)
		else $error("tone while tone disabled");
	fixed_dir_a: assert property (o_tx.drive_vld && i_cfg.dir_mode != SBT_DIR_TOGGLE
		|-> o_tx.drive_val == i_cfg.dir_mode[0]) else $error("fixed direction wrong");
	value_type_a: assert property (o_tx.value_vld
		|-> i_cfg.value_mode && o_tx.value_type == i_cfg.vtype) else $error("value telegram wrong");
	value_quiet_a: assert property (i_cfg.value_mode
		|-> !o_tx.drive_vld && !o_tx.step_vld) else $error("shutter telegram in value mode");
	dim_code_a: assert property (o_tx.dim_vld |-> o_tx.dim_val ==
		(i_cfg.addfn == SBT_AF_BRIGHTER ? DIM_BRIGHTER : DIM_DARKER)) else $error("dim code wrong");
	scene_code_a: assert property (o_tx.scene_vld |-> o_tx.scene_val ==
		{i_cfg.addfn == SBT_AF_SCENE_SAVE, 1'b0, i_cfg.scene_num}) else $error("scene byte wrong");
	byte_code_a: assert property (o_tx.byte_vld |-> o_tx.byte_val == i_cfg.add_value)
		else $error("byte value wrong");
	af_drive_dir_a: assert property (o_tx.af_drive_vld
		|-> o_tx.af_drive_val == (i_cfg.addfn == SBT_AF_DRIVE_DOWN)) else $error("extra drive dir wrong");
	hold_press_a: assert property (hold_m && $rose(i_button) |-> ##[1:3] o_tx.drive_vld)
		else $error("hold press sent no drive");
	hold_release_a: assert property (hold_m && $fell(i_button) |-> ##[1:3] o_tx.step_vld)
		else $error("hold release sent no step");
	cover property (o_tx.drive_vld);
	cover property (o_tx.step_vld);
	cover property (o_tone);
	cover property (o_tx.value_vld);
endmodule

bind sbt_shutter_button sbt_monitor i_sbt_monitor (.i_clock(i_clock), .i_reset_n(i_reset_n),
	.i_button(i_button), .i_cfg(i_cfg), .i_rx(i_rx), .o_tx(o_tx), .o_tone(o_tone),
	.o_driving(o_driving));

// [verif/sbt_bus_model.sv]
// Bus and shutter actuator model facing the button logic
`timescale 1ns/1ps
module sbt_bus_model
	import sbt_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire sbt_tx_t i_tx,
	input wire sbt_rx_t i_req,
	output sbt_rx_t o_rx,
	output logic o_moving
);
	// Received telegrams as one-cycle strobes
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n)
			o_rx <= '0;
		else
			o_rx <= i_req;
	end
	// Step command disabled: a step only stops
	always_ff @(posedge i_clock or negedge i_reset_n) begin
		if (!i_reset_n)
			o_moving <= 1'b0;
		else if (i_tx.drive_vld)
			o_moving <= 1'b1;
		else if (i_tx.step_vld)
			o_moving <= 1'b0;
	end
endmodule

// [verif/tb_top.sv]
// Testbench for the shutter button telegram logic
`timescale 1ns/1ps
module tb_top;
	import sbt_pkg::*;
	logic i_clock;
	logic i_reset_n;
	logic i_button;
	sbt_cfg_t cfg;
	sbt_rx_t rx;
	sbt_rx_t req;
	sbt_tx_t tx;
	logic tone;
	logic driving;
	logic moving;
	logic d_val;
	logic s_val;
	logic [15:0] v_val;
	int mismatches;
	int checks_done;
	int n_drv;
	int n_stp;
	int n_af;
	int n_val;
	int n_tone;

	sbt_shutter_button i_sbt_shutter_button (.i_clock(i_clock), .i_reset_n(i_reset_n),
		.i_button(i_button), .i_cfg(cfg), .i_rx(rx), .o_tx(tx), .o_tone(tone),
		.o_driving(driving));
	sbt_bus_model i_sbt_bus_model (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_tx(tx),
		.i_req(req), .o_rx(rx), .o_moving(moving));

	initial begin
		i_clock = 1'b0;
		forever #5 i_clock = ~i_clock;
	end
	// ------------------------------
	// Telegram capture
	// ------------------------------
	always @(negedge i_clock) begin
		n_drv += tx.drive_vld;
		n_stp += tx.step_vld;
		n_af += tx.sw_vld + tx.dim_vld + tx.af_drive_vld + tx.af_step_vld + tx.byte_vld;
		n_af += tx.scene_vld;
		n_val += tx.value_vld;
		n_tone += tone;
		if (tx.drive_vld)
			d_val = tx.drive_val;
		if (tx.sw_vld)
			s_val = tx.sw_val;
		if (tx.value_vld)
			v_val = tx.value_val;
	end
	// ------------------------------
	// Tasks
	// ------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge i_clock);
	endtask
	task automatic clr();
		n_drv = 0;
		n_stp = 0;
		n_af = 0;
		n_val = 0;
		n_tone = 0;
	endtask
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic start(input sbt_ctrl_t c, input logic [15:0] lt, input logic [15:0] tt);
		i_reset_n = 1'b0;
		cfg.ctrl = c;
		cfg.long_time = lt;
		cfg.turn_time = tt;
		cyc(2);
		i_reset_n = 1'b1;
		cyc(1);
		clr();
	endtask
	task automatic press(input int n);
		i_button = 1'b1;
		cyc(n);
		i_button = 1'b0;
		cyc(8);
	endtask
	task automatic pulse();
		cyc(1);
		req = '0;
		cyc(2);
	endtask
	task automatic tally(input int d, input int s, input int a);
		chk("drive", 16'(n_drv), 16'(d));
		chk("step", 16'(n_stp), 16'(s));
		chk("extra", 16'(n_af), 16'(a));
		clr();
	endtask
	task automatic final_report();
		$display("Checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ------------------------------
	// Watchdog
	// ------------------------------
	initial begin
		repeat (60000) @(posedge i_clock);
		mismatches++;
		final_report();
	end
	// ------------------------------
	// Scenarios
	// ------------------------------
	initial begin
		i_reset_n = 1'b0;
		i_button = 1'b0;
		req = '0;
		cfg = '0;
		cfg.dir_mode = SBT_DIR_UP;
		cfg.addfn = SBT_AF_ON;
		cfg.tone_en = 1'b1;
		cfg.write_en = 1'b1;
		cfg.very_long_time = TIME_MAX;
		cfg.drive_time = 16'h0001;
		cfg.add_value = 8'h5A;
		cfg.scene_num = 6'h07;
		cfg.vtype = SBT_VT_INT16;
		cfg.send_value = 16'h1234;
		start(SBT_UC_LONG_SHORT, 16'h0001, TIME_RST);
		press(5);
		tally(0, 1, 0);
		start(SBT_UC_LONG_SHORT, TIME_RST, TIME_RST);
		press(20);
		chk("moving", 16'(moving), 16'h0001);
		tally(1, 0, 0);
		cfg.very_long_en = 1'b1;
		cfg.very_long_time = TIME_RST;
		start(SBT_UC_LONG_SHORT, TIME_RST, TIME_RST);
		press(20);
		tally(1, 0, 1);
		cfg.very_long_en = 1'b0;
		start(SBT_UC_LONG_SHORT_TURN, TIME_RST, 16'h0001);
		press(20);
		tally(1, 1, 0);
		start(SBT_UC_LONG_SHORT_TURN, TIME_RST, TIME_RST);
		press(20);
		tally(1, 0, 0);
		start(SBT_UC_INVERTED, 16'h0001, TIME_RST);
		press(3);
		chk("window", 16'(driving), 16'h0001);
		tally(1, 0, 0);
		press(3);
		tally(0, 1, 0);
		start(SBT_UC_SHORT_LONG_TURN, TIME_RST, 16'h0001);
		press(20);
		tally(1, 1, 0);
		cfg.dir_mode = SBT_DIR_DOWN;
		start(SBT_UC_HOLD, 16'h0001, TIME_RST);
		press(20);
		chk("moving", 16'(moving), 16'h0000);
		chk("dir", 16'(d_val), 16'(DIR_DOWN));
		tally(1, 1, 0);
		start(SBT_UC_HOLD_TURN, 16'h0001, TIME_RST);
		press(20);
		chk("tone", 16'(n_tone), 16'h0001);
		tally(1, 0, 0);
		start(SBT_UC_HOLD_DELAYED, 16'h0001, TIME_RST);
		press(3);
		tally(0, 0, 1);
		for (int k = 1; k < 13; k++) begin
			cfg.addfn = sbt_addfn_t'(k);
			start(SBT_UC_SHORT_SHORT, TIME_RST, TIME_RST);
			press(20);
			tally(0, 0, 1);
		end
		cfg.addfn = SBT_AF_TOGGLE;
		start(SBT_UC_SHORT_SHORT, TIME_RST, TIME_RST);
		req.sw_vld = 1'b1;
		req.sw_val = 1'b1;
		pulse();
		press(20);
		chk("toggle", 16'(s_val), 16'h0000);
		cfg.dir_mode = SBT_DIR_TOGGLE;
		start(SBT_UC_LONG_SHORT, TIME_RST, TIME_RST);
		press(20);
		chk("dir", 16'(d_val), 16'(DIR_UP));
		req.pos_vld = 1'b1;
		req.pos_val = POS_CLOSED;
		pulse();
		press(20);
		chk("dir", 16'(d_val), 16'(DIR_UP));
		req.drive_vld = 1'b1;
		req.drive_val = DIR_DOWN;
		pulse();
		press(20);
		chk("dir", 16'(d_val), 16'(DIR_UP));
		press(20);
		chk("dir", 16'(d_val), 16'(DIR_DOWN));
		cfg.value_mode = 1'b1;
		start(SBT_UC_LONG_SHORT, 16'h0001, TIME_RST);
		press(3);
		chk("count", 16'(n_val), 16'h0001);
		chk("value", v_val, 16'h1234);
		cfg.vtype = SBT_VT_PERCENT;
		press(3);
		chk("value", v_val, 16'h0034);
		final_report();
	end
endmodule
